// ---- inc/fll_defines.svh ----
/*
 * constants of the clock generator configuration block: register offsets,
 * reset values, field positions, mode codes and timing counts.
 * assumes a 25 MHz system clock and an 8-bit register port.
 */
`ifndef FLL_DEFINES_SVH
`define FLL_DEFINES_SVH

// register offsets on the 8-bit register port
`define FLL_OFS_CTRL1 8'h00
`define FLL_OFS_CTRL2 8'h01
`define FLL_OFS_STAT1 8'h02
`define FLL_OFS_STAT2 8'h03
`define FLL_OFS_TRIM 8'h04

// reset values: self-clocked, multiplier 4, divide by one, trim centred
`define FLL_CTRL1_RST 8'h00
`define FLL_CTRL2_RST 8'h00
`define FLL_TRIM_RST 8'h80

// field positions
`define FLL_ST1_CLEAR_BIT 0
`define FLL_ST2_DCO_STABLE_BIT 0

// clock mode codes
`define FLL_MODE_SCM 2'b00
`define FLL_MODE_FEI 2'b01
`define FLL_MODE_FBE 2'b10
`define FLL_MODE_FEE 2'b11

// frequencies in kHz, reference divider, prescale factors and trim centre
`define FLL_CLK_KHZ 25000
`define FLL_SCM_KHZ 8000
`define FLL_IRG_KHZ 243
`define FLL_IRG_DIV 7
`define FLL_PRE_LOW 64
`define FLL_PRE_HIGH 1
`define FLL_TRIM_CENTRE 384

// timing: least time without a reference edge before a clock loss
`define FLL_LOC_TIMEOUT_NS 2000
`define FLL_LOC_CYCLES ((`FLL_LOC_TIMEOUT_NS * `FLL_CLK_KHZ + 999999) / 1000000)
// least settling time of the loop after a configuration change
`define FLL_SETTLE_NS 4000
`define FLL_SETTLE_CYCLES ((`FLL_SETTLE_NS * `FLL_CLK_KHZ + 999999) / 1000000)

`endif

// ---- inc/fll_pkg.sv ----
/*
 * types of the clock generator configuration block.
 * assumes fll_defines.svh is on the include path.
 */
`include "fll_defines.svh"

package fll_pkg;

	// clock scheme selected by the mode field
	typedef enum logic [1:0] {
		MODE_SCM = `FLL_MODE_SCM,
		MODE_FEI = `FLL_MODE_FEI,
		MODE_FBE = `FLL_MODE_FBE,
		MODE_FEE = `FLL_MODE_FEE
	} clock_mode_e;

	// control register one layout, bit 7 first
	typedef struct packed {
		logic gain_high;
		logic range_high;
		logic reference_select;
		clock_mode_e clock_mode_select;
		logic oscillator_stop_keep;
		logic clock_loss_detect_disable;
		logic unused;
	} ctrl1_s;

	// control register two layout, bit 7 first
	typedef struct packed {
		logic lock_loss_reset_enable;
		logic [2:0] multiplier_code;
		logic clock_loss_reset_enable;
		logic [2:0] divider_code;
	} ctrl2_s;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage : fll_pkg

// ---- src/fll_clock_generator_config.sv ----
/*
 * clock generator configuration block: control, status and trim registers,
 * loss-of-clock and loss-of-lock monitors, oscillator controls and the
 * resulting output and bus frequencies.
 * assumes an 8-bit register port on clk_in and an external reference pin
 * that is asynchronous to clk_in.
 */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fll_defines.svh"

// Notes on behaviour
// - reset starts self-clocked, 8 MHz output
// - mode 11 engages loop on external reference
// - mode 01 engages loop on internal reference
// - range bit one: high range, prescale 1
// - range bit zero: low range, prescale 64
// - internal engaged: reference/7 * 64 * N / R
// - multiplier field bits 6:4, 011 gives 10
// - divider field bits 2:0, 000 one, 001 two
// - gain bit zero selects low-power oscillator
// - reference select one requests crystal oscillator
// - control one bit 0 reads zero
// - lock loss interrupts unless reset enabled
// - clock loss interrupts unless reset enabled
// - status one read-only except flag clearing write
// - multiplier codes map to 4 through 18
// - divider codes map to 1 through 128
// - external engaged: reference * P * N / R
// - bypassed: DCO or external clock over R
module fll_clock_generator_config import fll_pkg::*; #(
	parameter int unsigned EXT_REF_KHZ = 4000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// register port
	input wire reg_req_s reg_req_in,
	output logic [7:0] rdata_out,
	// external reference pin
	input wire logic ext_ref_in,
	// oscillator controls
	output logic osc_enable_out,
	output logic osc_crystal_req_out,
	output logic osc_high_range_out,
	output logic osc_high_gain_out,
	output logic irg_enable_out,
	output logic dco_enable_out,
	// frequencies and events
	output logic [31:0] gen_clock_khz_out,
	output logic [31:0] bus_clock_khz_out,
	output logic irq_out,
	output logic reset_req_out
);

	localparam logic [15:0] LOC_CYCLES = 16'(`FLL_LOC_CYCLES);
	localparam logic [15:0] SETTLE_CYCLES = 16'(`FLL_SETTLE_CYCLES);

	ctrl1_s ctrl1_q; // control register one
	ctrl2_s ctrl2_q; // control register two
	logic [7:0] trim_q; // internal reference trim
	logic [7:0] rdata_q; // read data, one cycle after the strobe
	logic ext_meta_q; // synchroniser first stage
	logic ext_sync_q; // synchroniser second stage
	logic ext_prev_q; // previous synchronised level
	logic [15:0] loc_cnt_q; // cycles since the last reference edge
	logic ext_lost_q; // reference currently missing
	logic [15:0] settle_cnt_q; // cycles since the last configuration change
	logic locked_q; // loop locked
	logic lock_loss_q; // sticky lock loss flag
	logic clock_loss_q; // sticky clock loss flag
	logic reset_req_q; // reset request pulse
	logic [31:0] gen_khz_q; // registered output frequency
	logic [31:0] dec_khz; // decoded output frequency

	logic ext_edge; // rising edge of the reference
	logic ext_mode; // scheme uses the external reference
	logic engaged; // loop engaged
	logic settled; // settling time has passed
	logic cfg_wr; // write that changes the clock configuration
	logic st1_clear; // flag clearing write to status one
	logic loc_evt; // clock loss detected this cycle
	logic lol_evt; // lock lost this cycle
	logic dco_stable; // DCO running at its target

	// register port decode
	always_comb begin
		cfg_wr = reg_req_in.wr && (reg_req_in.addr == `FLL_OFS_CTRL1
			|| reg_req_in.addr == `FLL_OFS_CTRL2 || reg_req_in.addr == `FLL_OFS_TRIM);
		st1_clear = reg_req_in.wr && reg_req_in.addr == `FLL_OFS_STAT1
			&& reg_req_in.wdata[`FLL_ST1_CLEAR_BIT];
	end

	// mode classification
	always_comb begin
		ext_mode = ctrl1_q.clock_mode_select == MODE_FBE
			|| ctrl1_q.clock_mode_select == MODE_FEE;
		engaged = ctrl1_q.clock_mode_select == MODE_FEI
			|| ctrl1_q.clock_mode_select == MODE_FEE;
		settled = settle_cnt_q == SETTLE_CYCLES;
		ext_edge = ext_sync_q && !ext_prev_q;
	end

	// control register one; bit 0 is never stored
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl1_q <= ctrl1_s'(`FLL_CTRL1_RST);
		end else if (reg_req_in.wr && reg_req_in.addr == `FLL_OFS_CTRL1) begin
			ctrl1_q <= ctrl1_s'({reg_req_in.wdata[7:1], 1'b0});
		end
	end

	// control register two
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl2_q <= ctrl2_s'(`FLL_CTRL2_RST);
		end else if (reg_req_in.wr && reg_req_in.addr == `FLL_OFS_CTRL2) begin
			ctrl2_q <= ctrl2_s'(reg_req_in.wdata);
		end
	end

	// trim register, only steers the internal reference
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			trim_q <= `FLL_TRIM_RST;
		end else if (reg_req_in.wr && reg_req_in.addr == `FLL_OFS_TRIM) begin
			trim_q <= reg_req_in.wdata;
		end
	end

	// read data; unmapped offsets read zero
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_q <= 8'h00;
		end else if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				`FLL_OFS_CTRL1: begin
					rdata_q <= {ctrl1_q[7:1], 1'b0};
				end
				`FLL_OFS_CTRL2: begin
					rdata_q <= ctrl2_q;
				end
				`FLL_OFS_STAT1: begin
					// mode, reference present, irq, locked, loss flags
					rdata_q <= {ctrl1_q.clock_mode_select, ext_mode && !ext_lost_q,
						irq_out, locked_q, lock_loss_q, clock_loss_q, 1'b0};
				end
				`FLL_OFS_STAT2: begin
					rdata_q <= {7'h00, dco_stable};
				end
				`FLL_OFS_TRIM: begin
					rdata_q <= trim_q;
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// reference pin synchroniser and edge history
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_ref_in;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// clock loss monitor, active only with detection enabled
	always_comb begin
		loc_evt = ext_mode && !ctrl1_q.clock_loss_detect_disable && !ext_edge
			&& loc_cnt_q == LOC_CYCLES - 16'h1;
		lol_evt = locked_q && ctrl1_q.clock_mode_select == MODE_FEE && loc_evt;
	end

	// cycles since the last reference edge
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			loc_cnt_q <= 16'h0;
			ext_lost_q <= 1'b0;
		end else if (!ext_mode || ctrl1_q.clock_loss_detect_disable || ext_edge) begin
			loc_cnt_q <= 16'h0;
			ext_lost_q <= 1'b0;
		end else if (loc_cnt_q != LOC_CYCLES) begin
			loc_cnt_q <= loc_cnt_q + 16'h1;
			ext_lost_q <= loc_evt;
		end
	end

	// settling counter, restarted by any configuration write
	always_ff @(posedge clk_in) begin
		if (srst_in || cfg_wr) begin
			settle_cnt_q <= 16'h0;
		end else if (!settled) begin
			settle_cnt_q <= settle_cnt_q + 16'h1;
		end
	end

	// lock state of the loop
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= engaged && settled && !cfg_wr && !lol_evt
				&& !(ctrl1_q.clock_mode_select == MODE_FEE && ext_lost_q);
		end
	end

	// DCO is off when bypassed on the external clock
	assign dco_stable = settled && ctrl1_q.clock_mode_select != MODE_FBE
		&& !(ext_mode && ext_lost_q);

	// sticky loss flags: a new event wins over the clear
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lock_loss_q <= 1'b0;
			clock_loss_q <= 1'b0;
		end else begin
			lock_loss_q <= lol_evt || (lock_loss_q && !st1_clear);
			clock_loss_q <= loc_evt || (clock_loss_q && !st1_clear);
		end
	end

	// reset request when the matching reset enable is set
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reset_req_q <= 1'b0;
		end else begin
			reset_req_q <= (lol_evt && ctrl2_q.lock_loss_reset_enable)
				|| (loc_evt && ctrl2_q.clock_loss_reset_enable);
		end
	end

	// interrupt request when the reset enable is clear
	assign irq_out = (lock_loss_q && !ctrl2_q.lock_loss_reset_enable)
		|| (clock_loss_q && !ctrl2_q.clock_loss_reset_enable);

	// frequency calculator
	fll_rate_decoder #(
		.EXT_REF_KHZ(EXT_REF_KHZ)
	) u_rate (
		.ctrl1_in(ctrl1_q),
		.ctrl2_in(ctrl2_q),
		.trim_in(trim_q),
		.out_khz_out(dec_khz)
	);

	// registered output frequency
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			gen_khz_q <= 32'(`FLL_SCM_KHZ);
		end else begin
			gen_khz_q <= dec_khz;
		end
	end

	// outputs
	assign rdata_out = rdata_q;
	assign gen_clock_khz_out = gen_khz_q;
	assign bus_clock_khz_out = {1'b0, gen_khz_q[31:1]};
	assign reset_req_out = reset_req_q;
	assign osc_crystal_req_out = ctrl1_q.reference_select;
	assign osc_enable_out = (ext_mode || ctrl1_q.oscillator_stop_keep)
		&& ctrl1_q.reference_select;
	assign osc_high_range_out = ctrl1_q.range_high;
	assign osc_high_gain_out = ctrl1_q.gain_high;
	assign irg_enable_out = ctrl1_q.clock_mode_select == MODE_FEI;
	assign dco_enable_out = ctrl1_q.clock_mode_select != MODE_FBE;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// a configuration that holds for two cycles
	sequence s_fee_x10;
		(ctrl1_q.clock_mode_select == MODE_FEE && ctrl1_q.range_high
			&& ctrl2_q.multiplier_code == 3'b011 && ctrl2_q.divider_code == 3'b000) [*2];
	endsequence
	sequence s_fee_low_x4;
		(ctrl1_q.clock_mode_select == MODE_FEE && !ctrl1_q.range_high
			&& ctrl2_q.multiplier_code == 3'b000 && ctrl2_q.divider_code == 3'b000) [*2];
	endsequence
	sequence s_scm_div2;
		(ctrl1_q.clock_mode_select == MODE_SCM && ctrl2_q.divider_code == 3'b001) [*2];
	endsequence
	sequence s_fei_x10_div2;
		(ctrl1_q.clock_mode_select == MODE_FEI && trim_q == `FLL_TRIM_RST
			&& ctrl2_q.multiplier_code == 3'b011 && ctrl2_q.divider_code == 3'b001) [*2];
	endsequence
	sequence s_fbe_div4;
		(ctrl1_q.clock_mode_select == MODE_FBE && ctrl2_q.divider_code == 3'b010) [*2];
	endsequence

	a_reset_self_clocked: assert property (
		$fell(srst_in) |-> ctrl1_q.clock_mode_select == MODE_SCM
			&& gen_khz_q == 32'd8000 && bus_clock_khz_out == 32'd4000)
		else $error("not self-clocked at 8 MHz after reset");
	a_fee_mult_ten: assert property (
		s_fee_x10 |-> gen_khz_q == 32'(EXT_REF_KHZ) * 32'd10)
		else $error("external engaged high range x10 wrong");
	a_fee_low_prescale: assert property (
		s_fee_low_x4 |-> gen_khz_q == 32'(EXT_REF_KHZ) * 32'd256)
		else $error("low range prescale not 64");
	a_scm_div_two: assert property (
		s_scm_div2 |-> gen_khz_q == 32'd4000)
		else $error("self-clocked divide by two wrong");
	a_ctrl1_bit0_zero: assert property (
		reg_req_in.rd && reg_req_in.addr == `FLL_OFS_CTRL1 |=> rdata_out[0] == 1'b0)
		else $error("control one bit 0 read nonzero");
	a_lock_loss_irq: assert property (
		lol_evt && !ctrl2_q.lock_loss_reset_enable && !reg_req_in.wr
			|=> lock_loss_q && irq_out && !reset_req_out)
		else $error("lock loss did not interrupt");
	a_clock_loss_irq: assert property (
		loc_evt && !ctrl2_q.clock_loss_reset_enable && !reg_req_in.wr
			|=> clock_loss_q && irq_out && !reset_req_out)
		else $error("clock loss did not interrupt");
	a_flag_needs_clear: assert property (
		clock_loss_q && !st1_clear |=> clock_loss_q)
		else $error("clock loss flag dropped without clear");
	a_status_clear_write: assert property (
		st1_clear && !loc_evt && !lol_evt |=> !clock_loss_q && !lock_loss_q)
		else $error("status one clearing write failed");
	a_fei_x10_div2: assert property (
		s_fei_x10_div2 |-> gen_khz_q == 32'd11108)
		else $error("internal engaged x10 over two wrong");
	a_fbe_div_four: assert property (
		s_fbe_div4 |-> gen_khz_q == 32'(EXT_REF_KHZ) / 32'd4)
		else $error("bypassed external divide by four wrong");
	a_lock_loss_reset: assert property (
		lol_evt && ctrl2_q.lock_loss_reset_enable && !reg_req_in.wr |=> reset_req_out)
		else $error("lock loss with reset enable made no reset request");
	a_detect_off_quiet: assert property (
		ctrl1_q.clock_loss_detect_disable && !clock_loss_q && !reg_req_in.wr
			|=> !clock_loss_q)
		else $error("clock loss flagged with detection disabled");

endmodule : fll_clock_generator_config

`default_nettype wire

// ---- src/fll_rate_decoder.sv ----
/*
 * output frequency calculator: turns the mode, range, multiplier, divider
 * and trim settings into the generator output frequency in kHz.
 * assumes the external reference frequency is given as a parameter.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fll_defines.svh"

module fll_rate_decoder import fll_pkg::*; #(
	parameter int unsigned EXT_REF_KHZ = 4000
) (
	// settings
	input wire ctrl1_s ctrl1_in,
	input wire ctrl2_s ctrl2_in,
	input wire logic [7:0] trim_in,
	// result
	output logic [31:0] out_khz_out
);

	// multiplier code to factor: 4, 6, 8 ... 18
	function automatic logic [31:0] mult_factor(input logic [2:0] code);
		mult_factor = {28'h0, code, 1'b0} + 32'h4;
	endfunction : mult_factor

	logic [31:0] irg_khz; // trimmed internal reference
	logic [31:0] prescale; // reference prescale factor
	logic [31:0] base_khz; // frequency before the divider

	// frequency of the chosen scheme
	always_comb begin
		irg_khz = (32'(`FLL_IRG_KHZ) * (32'h100 + {24'h0, trim_in})) / 32'(`FLL_TRIM_CENTRE);
		// high range prescales by one, low range by 64
		prescale = ctrl1_in.range_high ? 32'(`FLL_PRE_HIGH) : 32'(`FLL_PRE_LOW);
		case (ctrl1_in.clock_mode_select)
			MODE_SCM: begin
				base_khz = 32'(`FLL_SCM_KHZ);
			end
			MODE_FBE: begin
				base_khz = 32'(EXT_REF_KHZ);
			end
			MODE_FEI: begin
				// reference select is ignored here
				base_khz = irg_khz * 32'(`FLL_PRE_LOW) * mult_factor(ctrl2_in.multiplier_code)
					/ 32'(`FLL_IRG_DIV);
			end
			MODE_FEE: begin
				base_khz = 32'(EXT_REF_KHZ) * prescale
					* mult_factor(ctrl2_in.multiplier_code);
			end
			default: begin
				base_khz = 32'(`FLL_SCM_KHZ);
			end
		endcase
		// divider: 1, 2, 4 ... 128
		out_khz_out = base_khz >> ctrl2_in.divider_code;
	end

endmodule : fll_rate_decoder

`default_nettype wire

// ---- verif/fll_ref_source_model.sv ----
/*
 * external reference source model: a free-running square wave standing in
 * for the crystal, resonator or external clock, which can be halted.
 * assumes run_in is driven by the bench and that the source is unrelated
 * in phase to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fll_ref_source_model #(
	parameter int unsigned HALF_NS = 125
) (
	// control from the bench
	input wire logic run_in,
	// reference pin
	output logic ref_out
);
	// free-running toggle; a halted source parks the pin at its last level,
	// which is exactly what the loss monitor has to notice
	initial begin
		ref_out = 1'b0;
		#7;
		forever begin
			#(HALF_NS);
			// only a running source makes edges
			if (run_in) begin
				ref_out = ~ref_out;
			end
		end
	end
endmodule : fll_ref_source_model

`default_nettype wire

// ---- verif/tb.sv ----
/*
 * self-checking bench of the clock generator configuration block: register
 * access, frequency selection in every scheme, loss monitors and flags.
 * assumes the package, the defines header and the reference source model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fll_defines.svh"

module tb import fll_pkg::*; ;
	// design ports
	logic clk_in, srst_in, ext_ref_in, ref_run;
	reg_req_s req;
	logic [7:0] rdata_out;
	logic osc_enable_out, osc_crystal_req_out, osc_high_range_out, osc_high_gain_out;
	logic irg_enable_out, dco_enable_out, irq_out, reset_req_out;
	logic [31:0] gen_clock_khz_out, bus_clock_khz_out;
	// tallies
	int n_fail = 0;
	int compares = 0;

	fll_clock_generator_config #(.EXT_REF_KHZ(4000)) fll_clock_generator_config_inst (
		.clk_in(clk_in), .srst_in(srst_in), .reg_req_in(req), .rdata_out(rdata_out),
		.ext_ref_in(ext_ref_in), .osc_enable_out(osc_enable_out),
		.osc_crystal_req_out(osc_crystal_req_out), .osc_high_range_out(osc_high_range_out),
		.osc_high_gain_out(osc_high_gain_out), .irg_enable_out(irg_enable_out),
		.dco_enable_out(dco_enable_out), .gen_clock_khz_out(gen_clock_khz_out),
		.bus_clock_khz_out(bus_clock_khz_out), .irq_out(irq_out),
		.reset_req_out(reset_req_out));

	fll_ref_source_model #(.HALF_NS(125)) fll_ref_source_model_inst (
		.run_in(ref_run), .ref_out(ext_ref_in));

	// 25 MHz system clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// compare and tally
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// end of run verdict
	task automatic give_verdict();
		if (n_fail == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// one-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk_in);
		req <= reg_req_s'({a, w, 2'b10});
		@(posedge clk_in);
		req <= '0;
	endtask : reg_wr

	// one-cycle read strobe, data taken in the cycle after it
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req <= reg_req_s'({a, 8'h00, 2'b01});
		@(posedge clk_in);
		req <= '0;
		#1;
		d = rdata_out;
	endtask : reg_rd

	// let a register write reach the frequency outputs
	task automatic settle();
		repeat (2) @(posedge clk_in);
		#1;
	endtask : settle

	// bounded wait for the interrupt or the reset request
	task automatic wait_evt(input bit want_rst);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk_in);
			#1;
			if (want_rst ? reset_req_out === 1'b1 : irq_out === 1'b1) return;
		end
		n_fail++;
		give_verdict();
	endtask : wait_evt

	// software polls the stable flag before relying on the clock
	task automatic wait_stable();
		logic [7:0] d;
		int i;
		for (i = 0; i < 300; i++) begin
			reg_rd(`FLL_OFS_STAT2, d);
			if (d[`FLL_ST2_DCO_STABLE_BIT] === 1'b1) return;
		end
		n_fail++;
		give_verdict();
	endtask : wait_stable

	// main sequence
	initial begin
		logic [7:0] d;
		int m, r;
		srst_in = 1'b1;
		req = '0;
		ref_run = 1'b1;
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		// state after reset
		settle();
		check(gen_clock_khz_out, 32'd8000);
		check(bus_clock_khz_out, 32'd4000);
		check(dco_enable_out, 1'b1);
		reg_rd(`FLL_OFS_CTRL1, d);
		check(d, `FLL_CTRL1_RST);
		reg_rd(`FLL_OFS_CTRL2, d);
		check(d, `FLL_CTRL2_RST);
		check(osc_enable_out, 1'b0);
		reg_rd(`FLL_OFS_TRIM, d);
		check(d, `FLL_TRIM_RST);
		reg_rd(8'h07, d);
		check(d, 8'h00);
		// engaged external, high range, N=10 R=1; bit 0 written as one
		reg_wr(`FLL_OFS_CTRL1, 8'h79);
		reg_wr(`FLL_OFS_CTRL2, 8'h30);
		settle();
		check(gen_clock_khz_out, 32'd40000);
		check(bus_clock_khz_out, 32'd20000);
		check(osc_high_range_out, 1'b1);
		check(osc_crystal_req_out, 1'b1);
		check(osc_enable_out, 1'b1);
		check(osc_high_gain_out, 1'b0);
		reg_rd(`FLL_OFS_CTRL1, d);
		check(d, 8'h78);
		// engaged external, low range, every multiplier and divider code
		reg_wr(`FLL_OFS_CTRL1, 8'h38);
		for (m = 0; m < 8; m++) begin
			for (r = 0; r < 8; r++) begin
				reg_wr(`FLL_OFS_CTRL2, {1'b0, 3'(m), 1'b0, 3'(r)});
				settle();
				check(gen_clock_khz_out, 32'((4000 * 64 * (4 + 2 * m)) >> r));
			end
		end
		check(osc_high_range_out, 1'b0);
		// engaged internal, N=10 R=2, with and without reference select
		reg_wr(`FLL_OFS_CTRL1, 8'h28);
		reg_wr(`FLL_OFS_CTRL2, 8'h31);
		settle();
		check(gen_clock_khz_out, 32'd11108);
		check(irg_enable_out, 1'b1);
		check(osc_enable_out, 1'b0);
		reg_wr(`FLL_OFS_CTRL1, 8'h08);
		settle();
		check(gen_clock_khz_out, 32'd11108);
		// keeping the oscillator on outside external modes
		reg_wr(`FLL_OFS_CTRL1, 8'h2c);
		settle();
		check(osc_enable_out, 1'b1);
		check(gen_clock_khz_out, 32'd11108);
		// trim at its lowest slows the internal reference
		reg_wr(`FLL_OFS_TRIM, 8'h00);
		settle();
		check(gen_clock_khz_out, 32'd7405);
		reg_wr(`FLL_OFS_TRIM, 8'h80);
		// trimming ran at twice the divider; restore R=1 afterwards
		reg_wr(`FLL_OFS_CTRL2, 8'h30);
		settle();
		check(gen_clock_khz_out, 32'd22217);
		// bypassed external, then self-clocked, both over R
		reg_wr(`FLL_OFS_CTRL1, 8'h30);
		reg_wr(`FLL_OFS_CTRL2, 8'h02);
		settle();
		check(gen_clock_khz_out, 32'd1000);
		check(dco_enable_out, 1'b0);
		reg_wr(`FLL_OFS_CTRL1, 8'h00);
		settle();
		check(gen_clock_khz_out, 32'd2000);
		reg_wr(`FLL_OFS_CTRL2, 8'h01);
		settle();
		check(gen_clock_khz_out, 32'd4000);
		// high gain, engaged external, interrupts on loss
		reg_wr(`FLL_OFS_CTRL1, 8'hf8);
		reg_wr(`FLL_OFS_CTRL2, 8'h30);
		settle();
		check(osc_high_gain_out, 1'b1);
		wait_stable();
		ref_run = 1'b0;
		wait_evt(1'b0);
		check(reset_req_out, 1'b0);
		ref_run = 1'b1;
		repeat (60) @(posedge clk_in);
		reg_rd(`FLL_OFS_STAT1, d);
		check(d[2:1], 2'b11);
		// a write without the clearing bit leaves the flags alone
		reg_wr(`FLL_OFS_STAT1, 8'hfe);
		reg_rd(`FLL_OFS_STAT1, d);
		check(d[2:1], 2'b11);
		reg_wr(`FLL_OFS_STAT1, 8'h01);
		reg_rd(`FLL_OFS_STAT1, d);
		check(d[2:1], 2'b00);
		check(irq_out, 1'b0);
		// detection disabled: a stopped reference raises nothing
		reg_wr(`FLL_OFS_CTRL1, 8'hfa);
		ref_run = 1'b0;
		repeat (80) @(posedge clk_in);
		reg_rd(`FLL_OFS_STAT1, d);
		check(d[2:1], 2'b00);
		check(irq_out, 1'b0);
		ref_run = 1'b1;
		reg_wr(`FLL_OFS_CTRL1, 8'hf8);
		// reset enables set: a one-cycle reset request, no interrupt
		reg_wr(`FLL_OFS_CTRL2, 8'hb8);
		wait_stable();
		ref_run = 1'b0;
		wait_evt(1'b1);
		check(irq_out, 1'b0);
		@(posedge clk_in);
		#1;
		check(reset_req_out, 1'b0);
		ref_run = 1'b1;
		reg_wr(`FLL_OFS_STAT1, 8'h01);
		// reset in mid-run returns to self-clocked
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		settle();
		check(gen_clock_khz_out, 32'd8000);
		check(bus_clock_khz_out, 32'd4000);
		check(osc_enable_out, 1'b0);
		reg_rd(`FLL_OFS_CTRL2, d);
		check(d, `FLL_CTRL2_RST);
		give_verdict();
	end
endmodule : tb

`default_nettype wire
